//--- verilog/adcc_config_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_config_ctrl import adcc_pkg::*; #(
  parameter int unsigned DAC_CH    = 12,
  parameter int unsigned ALARM_W   = 16
) (
  input  wire logic               REF_CLK,
  input  wire logic               RST_N,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  input  wire logic [6:0]         REG_ADDR,
  input  wire logic [15:0]        REG_WDATA,
  output var  logic [15:0]        REG_RDATA,
  input  wire logic               EXT_TRIG,
  input  wire logic               ADC_SEQ_DONE,
  output var  logic               ADC_SEQ_START,
  output var  logic               ADC_AUTO_MODE,
  input  wire logic [DAC_CH-1:0]  DAC_SYNC_UPDATE_SEL,
  output var  logic [DAC_CH-1:0]  DAC_LATCH_LOAD,
  output var  logic               REF_INT_BUF_EN,
  input  wire logic [ALARM_W-1:0] STATUS_ALARM,
  input  wire logic               ALARM_ACTIVE,
  output var  logic               FAULT_PIN_O,
  output var  logic               FAULT_PIN_OE,
  output var  logic               DATA_AVAILABLE_PIN_N
);
  localparam int unsigned PULSE_CYC = `ADCC_PULSE_CYC;

  // -------------------------------------------
  // helpers
  // -------------------------------------------
  function automatic logic in_range(adcc_addr_t a, adcc_addr_t lo, adcc_addr_t hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // -------------------------------------------
  // state
  // -------------------------------------------
  adcc_seq_e         state;
  adcc_seq_e         next_state;
  logic              conversion_mode_sel;
  logic              next_conversion_mode_sel;
  logic              soft_convert_start;
  logic              next_soft_convert_start;
  logic              sync_dac_load;
  logic              next_sync_dac_load;
  logic              ref_int;
  logic              next_ref_int;
  logic              fault_en;
  logic              next_fault_en;
  logic              data_available_flag;
  logic              next_data_available_flag;
  logic              global_fault_flag;
  logic              next_global_fault_flag;
  logic [DAC_CH-1:0] dac_written;
  logic [DAC_CH-1:0] next_dac_written;
  logic [DAC_CH-1:0] next_dac_latch_load;
  logic              next_seq_start;
  logic              next_fault_oe;
  logic              next_pin_n;
  adcc_word_t        next_rdata;
  logic              trig_s1;
  logic              trig_s2;
  logic              trig_s3;
  logic              trig_rise;
  logic              cfg_wr;
  logic              cfg_rd;
  logic              adc_rd;
  logic              status_rd;
  logic              dac_wr;
  logic              start_take;
  logic              seq_repeat;
  logic              seq_end_direct;
  logic [3:0]        dac_idx;
  adcc_word_t        cfg_word;

  adcc_pulse_if pulse ();

  adcc_pulse_timer #(
    .CYC (PULSE_CYC)
  ) u_pulse (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .pls   (pulse.timer)
  );

  // -------------------------------------------
  // trigger pin synchroniser
  // -------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= EXT_TRIG;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  assign trig_rise = trig_s2 & ~trig_s3;

  // -------------------------------------------
  // access decode
  // -------------------------------------------
  assign cfg_wr    = REG_WR && REG_ADDR == `ADCC_ADDR_CFG0;
  assign cfg_rd    = REG_RD && REG_ADDR == `ADCC_ADDR_CFG0;
  assign status_rd = REG_RD && REG_ADDR == `ADCC_ADDR_STATUS;
  assign adc_rd    = REG_RD && in_range(REG_ADDR, `ADCC_ADDR_ADC_LO, `ADCC_ADDR_ADC_HI);
  assign dac_wr    = REG_WR && in_range(REG_ADDR, `ADCC_ADDR_DAC_LO, `ADCC_ADDR_DAC_HI);
  assign dac_idx   = 4'(REG_ADDR - `ADCC_ADDR_DAC_LO);

  // -------------------------------------------
  // control bits
  // -------------------------------------------
  always_comb begin
    next_conversion_mode_sel = conversion_mode_sel;
    next_soft_convert_start  = soft_convert_start;
    next_sync_dac_load       = sync_dac_load;
    next_ref_int             = ref_int;
    next_fault_en            = fault_en;
    if (start_take) begin
      next_soft_convert_start = 1'b0; // R3
    end
    if (sync_dac_load) begin
      next_sync_dac_load = 1'b0; // R6
    end
    // a fresh write wins over the self-clear
    if (cfg_wr) begin
      next_conversion_mode_sel = REG_WDATA[`ADCC_BIT_MODE];
      next_soft_convert_start  = REG_WDATA[`ADCC_BIT_SWSTART];
      next_sync_dac_load       = REG_WDATA[`ADCC_BIT_DACLOAD];
      next_ref_int             = REG_WDATA[`ADCC_BIT_REFINT]; // R7
      next_fault_en            = REG_WDATA[`ADCC_BIT_FAULTEN];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      conversion_mode_sel <= 1'(`ADCC_CFG0_RESET >> `ADCC_BIT_MODE);
      soft_convert_start  <= 1'b0;
      sync_dac_load       <= 1'b0;
      ref_int             <= 1'b0;
      fault_en            <= 1'b0;
    end else begin
      conversion_mode_sel <= next_conversion_mode_sel;
      soft_convert_start  <= next_soft_convert_start;
      sync_dac_load       <= next_sync_dac_load;
      ref_int             <= next_ref_int;
      fault_en            <= next_fault_en;
    end
  end

  // -------------------------------------------
  // conversion sequencer
  // -------------------------------------------
  assign start_take     = soft_convert_start | trig_rise; // R3
  assign seq_repeat     = state == ADCC_SEQ_RUN && ADC_SEQ_DONE && !start_take && conversion_mode_sel;
  assign seq_end_direct = state == ADCC_SEQ_RUN && ADC_SEQ_DONE && !start_take && !conversion_mode_sel;

  always_comb begin
    next_state     = state;
    next_seq_start = 1'b0;
    pulse.fire     = 1'b0;
    case (state)
      ADCC_SEQ_IDLE: begin
        if (start_take) begin
          next_state     = ADCC_SEQ_RUN;
          next_seq_start = 1'b1;
        end
      end
      ADCC_SEQ_RUN: begin
        if (start_take) begin
          next_seq_start = 1'b1;
        end else if (seq_repeat) begin
          next_seq_start = 1'b1; // R2
          pulse.fire     = 1'b1; // R13
        end else if (seq_end_direct) begin
          next_state = ADCC_SEQ_IDLE; // R1
        end
      end
      default: begin
        next_state = ADCC_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state         <= ADCC_SEQ_IDLE;
      ADC_SEQ_START <= 1'b0;
    end else begin
      state         <= next_state;
      ADC_SEQ_START <= next_seq_start;
    end
  end

  // -------------------------------------------
  // data-available flag and pin
  // -------------------------------------------
  always_comb begin
    next_data_available_flag = data_available_flag;
    if (adc_rd || start_take || (cfg_wr && !REG_WDATA[`ADCC_BIT_DAFLAG])) begin
      next_data_available_flag = 1'b0; // R14
    end
    if (seq_end_direct) begin
      next_data_available_flag = 1'b1; // R10
    end
    if (next_conversion_mode_sel) begin
      next_data_available_flag = 1'b0; // R11
    end
    // registered pin lags the timer by one edge; width unchanged
    next_pin_n = next_conversion_mode_sel ? ~pulse.busy : ~next_data_available_flag; // R12 R13
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_available_flag  <= 1'b0;
      DATA_AVAILABLE_PIN_N <= 1'b1;
    end else begin
      data_available_flag  <= next_data_available_flag;
      DATA_AVAILABLE_PIN_N <= next_pin_n;
    end
  end

  // -------------------------------------------
  // sync DAC latch transfer
  // -------------------------------------------
  always_comb begin
    next_dac_latch_load = '0;
    next_dac_written    = dac_written;
    if (sync_dac_load) begin
      next_dac_latch_load = dac_written & DAC_SYNC_UPDATE_SEL; // R4 R5
      next_dac_written    = dac_written & ~DAC_SYNC_UPDATE_SEL;
    end
    // a data write in the transfer cycle stays pending
    if (dac_wr && dac_idx < DAC_CH) begin
      next_dac_written[dac_idx] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dac_written    <= '0;
      DAC_LATCH_LOAD <= '0;
    end else begin
      dac_written    <= next_dac_written;
      DAC_LATCH_LOAD <= next_dac_latch_load;
    end
  end

  // -------------------------------------------
  // global fault and fault pin
  // -------------------------------------------
  always_comb begin
    next_global_fault_flag = global_fault_flag;
    if (status_rd) begin
      next_global_fault_flag = 1'b0;
    end
    // a live alarm wins over the read clear
    if (|STATUS_ALARM) begin
      next_global_fault_flag = 1'b1; // R16
    end
    next_fault_oe = fault_en & ALARM_ACTIVE; // R8
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      global_fault_flag <= 1'b0;
      FAULT_PIN_OE      <= 1'b0;
    end else begin
      global_fault_flag <= next_global_fault_flag;
      FAULT_PIN_OE      <= next_fault_oe;
    end
  end

  assign FAULT_PIN_O    = 1'b0;
  assign ADC_AUTO_MODE  = conversion_mode_sel;
  assign REF_INT_BUF_EN = ref_int;

  // -------------------------------------------
  // read-back
  // -------------------------------------------
  always_comb begin
    cfg_word                     = '0; // R9
    cfg_word[`ADCC_BIT_MODE]     = conversion_mode_sel;
    cfg_word[`ADCC_BIT_SWSTART]  = soft_convert_start;
    cfg_word[`ADCC_BIT_DACLOAD]  = sync_dac_load;
    cfg_word[`ADCC_BIT_REFINT]   = ref_int;
    cfg_word[`ADCC_BIT_FAULTEN]  = fault_en;
    cfg_word[`ADCC_BIT_DAFLAG]   = data_available_flag;
    cfg_word[`ADCC_BIT_GFAULT]   = global_fault_flag;
    next_rdata                   = cfg_rd ? cfg_word : '0;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= '0;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  // -------------------------------------------
  // checks
  // -------------------------------------------
  logic [7:0] low_run;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_run <= '0;
    end else begin
      low_run <= DATA_AVAILABLE_PIN_N ? 8'h00 : low_run + 8'h01;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  chk_direct_idle: assert property (seq_end_direct |=> state == ADCC_SEQ_IDLE && data_available_flag) // R1
    else $error("direct sequence end not idle with flag");
  chk_auto_repeat: assert property (seq_repeat |=> ADC_SEQ_START && state == ADCC_SEQ_RUN) // R2
    else $error("auto mode did not restart");
  chk_soft_start: assert property (cfg_wr && REG_WDATA[`ADCC_BIT_SWSTART] // R3
    |=> soft_convert_start ##1 ADC_SEQ_START && (!soft_convert_start || $past(cfg_wr)))
    else $error("soft start not taken");
  chk_dac_load: assert property (sync_dac_load && !cfg_wr // R4 R5 R6
    |=> !sync_dac_load && (DAC_LATCH_LOAD & ~$past(DAC_SYNC_UPDATE_SEL)) == '0)
    else $error("sync dac load wrong");
  chk_ref_sel: assert property (cfg_wr |=> REF_INT_BUF_EN == $past(REG_WDATA[`ADCC_BIT_REFINT])) // R7
    else $error("reference select not applied");
  chk_fault_pin: assert property (FAULT_PIN_OE |-> $past(fault_en) && $past(ALARM_ACTIVE)) // R8
    else $error("fault pin driven while disabled");
  chk_reserved_zero: assert property (cfg_rd |=> (REG_RDATA & `ADCC_RSVD_MASK) == 16'h0000) // R9
    else $error("reserved bits read nonzero");
  chk_auto_flag: assert property (conversion_mode_sel |-> !data_available_flag) // R11
    else $error("flag set in auto mode");
  chk_direct_pin: assert property (!conversion_mode_sel |-> DATA_AVAILABLE_PIN_N == !data_available_flag) // R12
    else $error("pin does not mirror flag");
  chk_pulse_len: assert property ($rose(DATA_AVAILABLE_PIN_N) // R13
    && conversion_mode_sel && $past(conversion_mode_sel, 2) |-> low_run >= 8'(PULSE_CYC))
    else $error("auto pulse too short");
  chk_flag_clear: assert property (adc_rd && !seq_end_direct |=> !data_available_flag) // R14
    else $error("data read did not clear flag");
  chk_status_keep: assert property (status_rd && data_available_flag && !start_take && !REG_WR // R15
    |=> data_available_flag)
    else $error("status read cleared data flag");
  chk_fault_sticky: assert property (global_fault_flag && !status_rd |=> global_fault_flag) // R16
    else $error("global fault dropped early");

  cov_auto_repeat: cover property (seq_repeat ##1 ADC_SEQ_START);
  cov_direct_done: cover property (seq_end_direct ##1 !DATA_AVAILABLE_PIN_N);
  cov_dac_load:    cover property (DAC_LATCH_LOAD != '0);
  cov_fault:       cover property (global_fault_flag ##1 status_rd);
endmodule
`default_nettype wire

//--- verilog/adcc_cfg.svh
// Function
// (R1) mode 0: one sequence, then idle
// (R2) mode 1: repeat sequences until mode cleared
// (R3) software start begins conversion, self-clears
// (R4) load bit latches written sync-mode DAC channels
// (R5) sync latch updates only on load bit
// (R6) load bit self-clears after latch transfer
// (R7) reference bit selects internal buffered reference
// (R8) fault pin enable bit gates fault pin
// (R9) reserved bits ignore writes, read zero
// (R10) direct mode: flag set when sequence completes
// (R11) auto mode: flag held at zero
// (R12) direct mode: pin is inverted flag
// (R13) auto mode: 1 us low pulse per sequence
// (R14) flag cleared by data read, start, write-zero
// (R15) status read leaves data flag alone
// (R16) global fault sticky OR, cleared by status read
// (R17) host waits on flag before reading results
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

`define ADCC_ADDR_CFG0     7'h4C
`define ADCC_ADDR_STATUS   7'h4F
`define ADCC_ADDR_ADC_LO   7'h23
`define ADCC_ADDR_ADC_HI   7'h32
`define ADCC_ADDR_DAC_LO   7'h33
`define ADCC_ADDR_DAC_HI   7'h3E
`define ADCC_CFG0_RESET    16'h2000
`define ADCC_RSVD_MASK     16'hC13F
`define ADCC_BIT_MODE      13
`define ADCC_BIT_SWSTART   12
`define ADCC_BIT_DACLOAD   11
`define ADCC_BIT_REFINT    10
`define ADCC_BIT_FAULTEN   9
`define ADCC_BIT_DAFLAG    7
`define ADCC_BIT_GFAULT    6
`define ADCC_CLK_PERIOD_NS 40
`define ADCC_PULSE_NS      1000
`define ADCC_PULSE_CYC     ((`ADCC_PULSE_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)

`endif

//--- verilog/adcc_pkg.sv
package adcc_pkg;
  typedef enum logic {
    ADCC_SEQ_IDLE,
    ADCC_SEQ_RUN
  } adcc_seq_e;
  typedef logic [6:0]  adcc_addr_t;
  typedef logic [15:0] adcc_word_t;
endpackage

//--- verilog/adcc_pulse_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcc_pulse_if;
  logic fire;
  logic busy;
  modport ctrl  (output fire, input busy);
  modport timer (input fire, output busy);
endinterface
`default_nettype wire

//--- verilog/adcc_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_pulse_timer import adcc_pkg::*; #(
  parameter int unsigned CYC = 25
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  adcc_pulse_if.timer    pls
);
  localparam int unsigned CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // -------------------------------------------
  // retrigger reloads the full width
  // -------------------------------------------
  always_comb begin
    next_cnt = cnt;
    if (pls.fire) begin
      next_cnt = CW'(CYC);
    end else if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign pls.busy = (cnt != '0);

  chk_timer_load: assert property (@(posedge clk) disable iff (!rst_n) // R13
    pls.fire |=> pls.busy && cnt == CW'(CYC))
    else $error("pulse timer did not load");
endmodule
`default_nettype wire

//--- testbench/adcc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// converter stand-in: answers the latest start
// ----------------------------------------
module adcc_conv_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [7:0]  lat,
  output var  logic        done,
  output var  logic [15:0] n_start
);
  logic [7:0] cnt;

  // done only ever follows a start; a new start restarts the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= 8'h00;
      done    <= 1'b0;
      n_start <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt     <= lat;
        n_start <= n_start + 16'h0001;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_cfg.svh"
module tb_top import adcc_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        seq_done;
  logic        seq_start;
  logic        auto_mode;
  logic [11:0] sync_sel = 12'h000;
  logic [11:0] latch_load;
  logic        ref_buf_en;
  logic [15:0] status_alarm = 16'h0000;
  logic        alarm_active = 1'b0;
  logic        ext_trig = 1'b0;
  logic        fault_o;
  logic        fault_oe;
  logic        dav_pin_n;
  logic [7:0]  lat = 8'h08;
  logic [15:0] n_start;
  logic [15:0] got;
  int          n_mismatch = 0;
  int          n_tests = 0;

  always #20 clk = ~clk;

  adcc_config_ctrl i_adcc_config_ctrl (
    .REF_CLK(clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .EXT_TRIG(ext_trig), .ADC_SEQ_DONE(seq_done),
    .ADC_SEQ_START(seq_start), .ADC_AUTO_MODE(auto_mode), .DAC_SYNC_UPDATE_SEL(sync_sel),
    .DAC_LATCH_LOAD(latch_load), .REF_INT_BUF_EN(ref_buf_en), .STATUS_ALARM(status_alarm),
    .ALARM_ACTIVE(alarm_active), .FAULT_PIN_O(fault_o), .FAULT_PIN_OE(fault_oe),
    .DATA_AVAILABLE_PIN_N(dav_pin_n));

  adcc_conv_model i_adcc_conv_model (
    .clk(clk), .rst_n(rst_n), .start(seq_start), .lat(lat), .done(seq_done), .n_start(n_start));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data is registered at the taking edge and stands one cycle
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_reserved();
    rd(`ADCC_ADDR_CFG0, got);
    chk("cfg reset", got, `ADCC_CFG0_RESET);
    chk("pin after reset", {15'h0000, dav_pin_n}, 16'h0001);
    wr(`ADCC_ADDR_CFG0, `ADCC_RSVD_MASK);
    rd(`ADCC_ADDR_CFG0, got);
    chk("reserved bits", got, 16'h0000);
    rd(7'h4D, got);
    chk("unmapped read", got, 16'h0000);
  endtask

  task automatic t_ref_fault();
    alarm_active <= 1'b1;
    wr(`ADCC_ADDR_CFG0, 16'h0600);
    tick(2);
    chk("ref buffer on", {15'h0000, ref_buf_en}, 16'h0001);
    chk("fault pin on", {14'h0000, fault_oe, fault_o}, 16'h0002);
    wr(`ADCC_ADDR_CFG0, 16'h0400);
    tick(2);
    chk("fault pin off", {15'h0000, fault_oe}, 16'h0000);
    wr(`ADCC_ADDR_CFG0, 16'h0000);
    tick(2);
    chk("ref buffer off", {15'h0000, ref_buf_en}, 16'h0000);
    alarm_active <= 1'b0;
  endtask

  // host waits 20 cycles, checks the flag, peeks status, then reads data to clear
  task automatic t_direct();
    logic [15:0] s0;
    s0 = n_start;
    wr(`ADCC_ADDR_CFG0, 16'h1000);
    rd(`ADCC_ADDR_CFG0, got);
    chk("start self-clear, busy", got, 16'h0000);
    chk("one start", n_start, s0 + 16'h0001);
    tick(20);
    rd(`ADCC_ADDR_CFG0, got);
    chk("flag set", got, 16'h0080);
    chk("pin low", {15'h0000, dav_pin_n}, 16'h0000);
    rd(`ADCC_ADDR_STATUS, got);
    rd(`ADCC_ADDR_CFG0, got);
    chk("status read keeps flag", got, 16'h0080);
    rd(`ADCC_ADDR_ADC_LO, got);
    rd(`ADCC_ADDR_CFG0, got);
    chk("data read clears", got, 16'h0000);
    chk("pin high", {15'h0000, dav_pin_n}, 16'h0001);
    chk("no repeat", n_start, s0 + 16'h0001);
    wr(`ADCC_ADDR_CFG0, 16'h1000);
    tick(20);
    rd(`ADCC_ADDR_CFG0, got);
    chk("flag again", got, 16'h0080);
    wr(`ADCC_ADDR_CFG0, 16'h0000);
    rd(`ADCC_ADDR_CFG0, got);
    chk("write zero clears", got, 16'h0000);
    ext_trig <= 1'b1;
    tick(30);
    ext_trig <= 1'b0;
    rd(`ADCC_ADDR_CFG0, got);
    chk("trigger run", got, 16'h0080);
    chk("trigger start", n_start, s0 + 16'h0003);
    wr(`ADCC_ADDR_CFG0, 16'h1080);
    rd(`ADCC_ADDR_CFG0, got);
    chk("start clears flag", got, 16'h0000);
    tick(20);
    rd(`ADCC_ADDR_CFG0, got);
    chk("flag after start", got, 16'h0080);
  endtask

  task automatic wait_low_width(output int w);
    int i;
    w = 0;
    for (i = 0; i < 300 && dav_pin_n !== 1'b0; i++) tick(1);
    for (i = 0; i < 300 && dav_pin_n === 1'b0; i++) begin
      w++;
      tick(1);
    end
  endtask

  // long converter latency so each pulse ends before the next done
  task automatic t_auto();
    int w;
    logic [15:0] s1;
    lat <= 8'h28;
    wr(`ADCC_ADDR_CFG0, 16'h2080);
    rd(`ADCC_ADDR_CFG0, got);
    chk("auto forces flag", got, 16'h2000);
    wr(`ADCC_ADDR_CFG0, 16'h3000);
    wait_low_width(w);
    chk("pulse width", 16'(w), 16'(`ADCC_PULSE_CYC));
    rd(`ADCC_ADDR_CFG0, got);
    chk("auto flag zero", got, 16'h2000);
    wait_low_width(w);
    chk("second pulse", 16'(w), 16'(`ADCC_PULSE_CYC));
    chk("auto level", {15'h0000, auto_mode}, 16'h0001);
    wr(`ADCC_ADDR_CFG0, 16'h0000);
    tick(100);
    s1 = n_start;
    tick(100);
    chk("stops after clear", n_start, s1);
    rd(`ADCC_ADDR_ADC_LO, got);
    lat <= 8'h08;
  endtask

  task automatic t_dac();
    sync_sel <= 12'h00F;
    wr(7'h33, 16'h0123);
    wr(7'h35, 16'h0456);
    wr(7'h3B, 16'h0789);
    wr(`ADCC_ADDR_CFG0, 16'h0800);
    tick(1);
    chk("latch load", {4'h0, latch_load}, 16'h0005);
    tick(1);
    chk("latch load ends", {4'h0, latch_load}, 16'h0000);
    rd(`ADCC_ADDR_CFG0, got);
    chk("load self-clear", got, 16'h0000);
    wr(`ADCC_ADDR_CFG0, 16'h0800);
    tick(1);
    chk("no reload unwritten", {4'h0, latch_load}, 16'h0000);
  endtask

  task automatic t_gfault();
    @(posedge clk);
    status_alarm <= 16'h0010;
    @(posedge clk);
    status_alarm <= 16'h0000;
    tick(3);
    rd(`ADCC_ADDR_CFG0, got);
    chk("global fault sticky", got, 16'h0040);
    rd(`ADCC_ADDR_STATUS, got);
    rd(`ADCC_ADDR_CFG0, got);
    chk("global fault cleared", got, 16'h0000);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_reserved();
    t_ref_fault();
    t_direct();
    t_auto();
    t_dac();
    t_gfault();
    tick(5);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
